// ### logic/sys_copro_regs.vh
// Register numbers, field positions, reset values and fault codes of the control coprocessor.
`ifndef SYS_COPRO_REGS_VH
`define SYS_COPRO_REGS_VH

`define CP_REG_IDENT 4'h0
`define CP_REG_CTRL 4'h1
`define CP_REG_TTB 4'h2
`define CP_REG_DAC 4'h3
`define CP_REG_RSVD4 4'h4
`define CP_REG_FSR 4'h5
`define CP_REG_FAR 4'h6
`define CP_REG_CACHEOP 4'h7
`define CP_REG_TLBOP 4'h8
`define CP_REG_CACHELOCK 4'h9
`define CP_REG_TLBLOCK 4'hA
`define CP_REG_RSVD11 4'hB
`define CP_REG_RSVD12 4'hC
`define CP_REG_PID 4'hD
`define CP_REG_RSVD14 4'hE
`define CP_REG_TEST 4'hF

`define INS_COND_HI 31
`define INS_COND_LO 28
`define INS_CLASS_HI 27
`define INS_CLASS_LO 24
`define INS_OP1_HI 23
`define INS_OP1_LO 21
`define INS_DIR 20
`define INS_CRN_HI 19
`define INS_CRN_LO 16
`define INS_RD_HI 15
`define INS_RD_LO 12
`define INS_CPNUM_HI 11
`define INS_CPNUM_LO 8
`define INS_OP2_HI 7
`define INS_OP2_LO 5
`define INS_XFER 4
`define INS_CRM_HI 3
`define INS_CRM_LO 0
`define INS_CLASS_XFER 4'hE
`define INS_CLASS_MEM 3'h6
`define INS_CPNUM_SYS 4'hF
`define DIR_TO_COPRO 1'h0
`define DIR_FROM_COPRO 1'h1

`define CTRL_MMU_EN 0
`define CTRL_ALIGN_EN 1
`define CTRL_SYS_PROT 8
`define CTRL_ROM_PROT 9
`define CTRL_RESET 32'h00000078
`define ZERO_RESET 32'h00000000

`define TLBOP_CRM_INSTR 4'h5
`define TLBOP_CRM_DATA 4'h6
`define TLBOP_CRM_BOTH 4'h7
`define LOCK_OP2_INSTR 3'h1
`define IDENT_OP2_CACHE 3'h1

`define PG_SECTION 2'h0
`define PG_LARGE 2'h1
`define PG_SMALL 2'h2
`define PG_TINY 2'h3

`define FS_ALIGN 4'h1
`define FS_LINE_SECT 4'h4
`define FS_TRANS_SECT 4'h5
`define FS_MEM_SECT 4'h8
`define FS_DOM_SECT 4'h9
`define FS_WALK_L1 4'hC
`define FS_PERM_SECT 4'hD
`define FS_WALK_L2 4'hE
`define FS_PAGE_BIT 1

`endif

// ### logic/copro_instr_decode.v
// Field decoder for coprocessor instructions aimed at the control coprocessor.
`timescale 1ns/10ps
`include "sys_copro_regs.vh"
module copro_instr_decode
(
	input wire [31:0] instr,
	output wire forSysCopro,
	output wire isTransfer,
	output wire isOtherOp,
	output wire readDir,
	output wire [3:0] cond,
	output wire [2:0] op1,
	output wire [3:0] primary_coproc_register,
	output wire [3:0] rd,
	output wire [2:0] op2,
	output wire [3:0] secondary_coproc_register
);
	wire classXfer;
	wire classMem;

	assign classXfer = instr[`INS_CLASS_HI:`INS_CLASS_LO] == `INS_CLASS_XFER;
	assign classMem = instr[`INS_CLASS_HI:`INS_CLASS_LO + 1] == `INS_CLASS_MEM;
	assign forSysCopro = (classXfer | classMem) &
		(instr[`INS_CPNUM_HI:`INS_CPNUM_LO] == `INS_CPNUM_SYS);
	assign isTransfer = classXfer & instr[`INS_XFER];
	// Data operations and memory transfers to this coprocessor are flagged for trapping.
	assign isOtherOp = classMem | (classXfer & ~instr[`INS_XFER]);
	assign readDir = instr[`INS_DIR];
	assign cond = instr[`INS_COND_HI:`INS_COND_LO];
	assign op1 = instr[`INS_OP1_HI:`INS_OP1_LO];
	assign primary_coproc_register = instr[`INS_CRN_HI:`INS_CRN_LO];
	assign rd = instr[`INS_RD_HI:`INS_RD_LO];
	assign op2 = instr[`INS_OP2_HI:`INS_OP2_LO];
	assign secondary_coproc_register = instr[`INS_CRM_HI:`INS_CRM_LO];
endmodule

// ### logic/mmu_fault_check.v
// Fault classifier for one address port of the memory management unit.
`timescale 1ns/10ps
`include "sys_copro_regs.vh"
module mmu_fault_check
(
	input wire mmuOn,
	input wire alignOn,
	input wire sysProt,
	input wire romProt,
	input wire privileged,
	input wire [31:0] domainAccess,
	input wire [31:0] addr,
	input wire [1:0] size,
	input wire write,
	input wire descValid,
	input wire [1:0] pageSize,
	input wire [3:0] domain,
	input wire [7:0] apAll,
	input wire lineAbort,
	input wire memAbort,
	input wire walkAbort,
	input wire walkLevel2,
	output reg fault,
	output reg [3:0] status
);
	reg misaligned;
	reg [1:0] dom;
	reg [1:0] ap;
	reg permOk;
	reg isPage;

	always @*
	begin
		misaligned = (size == 2'h1 && addr[0]) || (size == 2'h2 && addr[1:0] != 2'h0);
		dom = domainAccess[{domain, 1'b0} +: 2];
		isPage = pageSize != `PG_SECTION;
		// Large and small pages pick one of four subpage permissions.
		case (pageSize)
			`PG_LARGE: ap = apAll[{addr[15:14], 1'b0} +: 2];
			`PG_SMALL: ap = apAll[{addr[11:10], 1'b0} +: 2];
			default: ap = apAll[1:0];
		endcase
		case (ap)
			2'h0: permOk = ~write & (privileged ? (sysProt | romProt) : romProt);
			2'h1: permOk = privileged;
			2'h2: permOk = privileged | ~write;
			default: permOk = 1'b1;
		endcase
		fault = 1'b1;
		status = 4'h0;
		if (alignOn && misaligned)
			status = `FS_ALIGN;
		else if (mmuOn && walkAbort)
			status = walkLevel2 ? `FS_WALK_L2 : `FS_WALK_L1;
		else if (mmuOn && !descValid)
		begin
			status = `FS_TRANS_SECT;
			status[`FS_PAGE_BIT] = isPage;
		end
		else if (mmuOn && (dom == 2'h0 || dom == 2'h2))
		begin
			status = `FS_DOM_SECT;
			status[`FS_PAGE_BIT] = isPage;
		end
		else if (mmuOn && dom == 2'h1 && !permOk)
		begin
			status = `FS_PERM_SECT;
			status[`FS_PAGE_BIT] = isPage;
		end
		else if (lineAbort)
		begin
			status = `FS_LINE_SECT;
			status[`FS_PAGE_BIT] = isPage;
		end
		else if (memAbort)
		begin
			status = `FS_MEM_SECT;
			status[`FS_PAGE_BIT] = isPage;
		end
		else
			fault = 1'b0;
	end
endmodule

// ### logic/system_control_coprocessor.v
// Control coprocessor register port with memory management fault reporting.
`timescale 1ns/10ps
`include "sys_copro_regs.vh"
// Behaviour
// - Compact-state registers 0..7 map to core 0..7
// - Sixteen coprocessor registers selected by number
// - Only privileged register moves reach the registers
// - Other coprocessor instructions raise undefined exception
// - Move-to writes register; move-from returns it
// - Recognise condition, class 1110, coprocessor all ones
// - Direction bit: 0 write, 1 read
// - Bits 3..0 select secondary register action
// - Bits 7..5 are secondary opcode, normally zero
// - Bits 19..16 select primary register
// - Bits 23..21 carry primary opcode field
// - Identification read-only, operations write-only, reserved none
// - Sections, large, small, tiny pages; subpage permissions
// - Instruction and data buffers flushed, locked separately
// - Sixteen domains governed by domain access register
// - Detect alignment, translation, domain, permission faults
// - Faulting access aborted and reported to core
// - Data faults record status and address
// - Instruction faults abort without recording anything
// - Line fetch, access and walk can abort
// - Both instruction and data ports are checked
// - Control bit 1 alignment check, bit 0 enable
module system_control_coprocessor
#(
	parameter [31:0] IDENT_CODE = 32'h12345670,
	parameter [31:0] CACHE_TYPE = 32'h0A000000
)
(
	input wire sys_clk,
	input wire rstn,
	input wire [2:0] compactRegNum,
	output reg [3:0] physRegNum,
	input wire cpInstrValid,
	input wire [31:0] cpInstr,
	input wire cpCondPass,
	input wire cpPrivileged,
	input wire [31:0] cpWriteData,
	output reg cpDone,
	output reg cpUndefined,
	output reg cpReadValid,
	output reg [3:0] cpReadReg,
	output reg [31:0] cpReadData,
	output reg mmuEnable,
	output reg alignCheckEnable,
	output reg [31:0] controlWord,
	output reg [31:0] tableBase,
	output reg [31:0] processIdRemap,
	output reg [31:0] cacheLockdown,
	output reg [31:0] instrTlbLockdown,
	output reg [31:0] dataTlbLockdown,
	output reg cacheOpStrobe,
	output reg [2:0] cacheOpCode,
	output reg [3:0] cacheOpSelect,
	output reg [31:0] cacheOpData,
	output reg instrTlbFlush,
	output reg dataTlbFlush,
	output reg [31:0] tlbOpData,
	input wire iAccValid,
	input wire [31:0] iAccAddr,
	input wire iDescValid,
	input wire [1:0] iPageSize,
	input wire [3:0] iDomain,
	input wire [7:0] iApAll,
	input wire iLineAbort,
	input wire iMemAbort,
	input wire iWalkAbort,
	input wire iWalkLevel2,
	output reg instrAbort,
	input wire dAccValid,
	input wire [31:0] dAccAddr,
	input wire [1:0] dAccSize,
	input wire dAccWrite,
	input wire dDescValid,
	input wire [1:0] dPageSize,
	input wire [3:0] dDomain,
	input wire [7:0] dApAll,
	input wire dLineAbort,
	input wire dMemAbort,
	input wire dWalkAbort,
	input wire dWalkLevel2,
	output reg dataAbort,
	output reg [31:0] faultStatus,
	output reg [31:0] faultAddress
);
	reg rstMeta;
	reg rstSync;
	reg [31:0] domainAccess;
	reg legal;
	reg [31:0] readValue;
	wire forSys;
	wire isTransfer;
	wire isOtherOp;
	wire readDir;
	wire [3:0] primary_coproc_register;
	wire [3:0] rd;
	wire [2:0] op2;
	wire [3:0] secondary_coproc_register;
	wire issue;
	wire doWrite;
	wire doRead;
	wire iFault;
	wire [3:0] iStatus;
	wire dFault;
	wire [3:0] dStatus;
	wire dataFault;

	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end
		else
		begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	copro_instr_decode decoder
	(
		.instr(cpInstr),
		.forSysCopro(forSys),
		.isTransfer(isTransfer),
		.isOtherOp(isOtherOp),
		.readDir(readDir),
		.cond(),
		.op1(),
		.primary_coproc_register(primary_coproc_register),
		.rd(rd),
		.op2(op2),
		.secondary_coproc_register(secondary_coproc_register)
	);

	// Access legality per register number and direction.
	always @*
	begin
		case (primary_coproc_register)
			`CP_REG_IDENT: legal = readDir == `DIR_FROM_COPRO;
			`CP_REG_CACHEOP, `CP_REG_TLBOP: legal = readDir == `DIR_TO_COPRO;
			`CP_REG_CTRL, `CP_REG_TTB, `CP_REG_DAC, `CP_REG_FSR, `CP_REG_FAR,
			`CP_REG_CACHELOCK, `CP_REG_TLBLOCK, `CP_REG_PID: legal = 1'b1;
			default: legal = 1'b0;
		endcase
	end

	assign issue = cpInstrValid & cpCondPass & forSys;
	assign doWrite = issue & isTransfer & cpPrivileged & legal &
		(readDir == `DIR_TO_COPRO);
	assign doRead = issue & isTransfer & cpPrivileged & legal &
		(readDir == `DIR_FROM_COPRO);

	always @*
	begin
		case (primary_coproc_register)
			`CP_REG_IDENT: readValue = (op2 == `IDENT_OP2_CACHE) ? CACHE_TYPE : IDENT_CODE;
			`CP_REG_CTRL: readValue = controlWord;
			`CP_REG_TTB: readValue = tableBase;
			`CP_REG_DAC: readValue = domainAccess;
			`CP_REG_FSR: readValue = faultStatus;
			`CP_REG_FAR: readValue = faultAddress;
			`CP_REG_CACHELOCK: readValue = cacheLockdown;
			`CP_REG_TLBLOCK:
				readValue = (op2 == `LOCK_OP2_INSTR) ? instrTlbLockdown : dataTlbLockdown;
			`CP_REG_PID: readValue = processIdRemap;
			default: readValue = `ZERO_RESET;
		endcase
	end

	// Instruction answer: one cycle after the issue, a done or an undefined pulse.
	always @(posedge sys_clk or negedge rstSync)
	begin
		if (!rstSync)
		begin
			cpDone <= 1'b0;
			cpUndefined <= 1'b0;
			cpReadValid <= 1'b0;
			cpReadReg <= 4'h0;
			cpReadData <= `ZERO_RESET;
			physRegNum <= 4'h0;
		end
		else
		begin
			physRegNum <= {1'b0, compactRegNum};
			cpDone <= doWrite | doRead;
			cpUndefined <= issue & (isOtherOp | ~cpPrivileged | ~legal);
			cpReadValid <= doRead;
			if (doRead)
			begin
				cpReadReg <= rd;
				cpReadData <= readValue;
			end
		end
	end

	// Writable configuration registers.
	always @(posedge sys_clk or negedge rstSync)
	begin
		if (!rstSync)
		begin
			controlWord <= `CTRL_RESET;
			tableBase <= `ZERO_RESET;
			domainAccess <= `ZERO_RESET;
			cacheLockdown <= `ZERO_RESET;
			instrTlbLockdown <= `ZERO_RESET;
			dataTlbLockdown <= `ZERO_RESET;
			processIdRemap <= `ZERO_RESET;
		end
		else if (doWrite)
		begin
			case (primary_coproc_register)
				`CP_REG_CTRL: controlWord <= cpWriteData;
				`CP_REG_TTB: tableBase <= cpWriteData;
				`CP_REG_DAC: domainAccess <= cpWriteData;
				`CP_REG_CACHELOCK: cacheLockdown <= cpWriteData;
				`CP_REG_TLBLOCK:
				begin
					if (op2 == `LOCK_OP2_INSTR)
						instrTlbLockdown <= cpWriteData;
					else
						dataTlbLockdown <= cpWriteData;
				end
				`CP_REG_PID: processIdRemap <= cpWriteData;
				default: processIdRemap <= processIdRemap;
			endcase
		end
	end

	always @*
	begin
		mmuEnable = controlWord[`CTRL_MMU_EN];
		alignCheckEnable = controlWord[`CTRL_ALIGN_EN];
	end

	// Write-only operation registers turn into one-cycle strobes.
	always @(posedge sys_clk or negedge rstSync)
	begin
		if (!rstSync)
		begin
			cacheOpStrobe <= 1'b0;
			cacheOpCode <= 3'h0;
			cacheOpSelect <= 4'h0;
			cacheOpData <= `ZERO_RESET;
			instrTlbFlush <= 1'b0;
			dataTlbFlush <= 1'b0;
			tlbOpData <= `ZERO_RESET;
		end
		else
		begin
			cacheOpStrobe <= doWrite && primary_coproc_register == `CP_REG_CACHEOP;
			instrTlbFlush <= doWrite && primary_coproc_register == `CP_REG_TLBOP &&
				(secondary_coproc_register == `TLBOP_CRM_INSTR || secondary_coproc_register == `TLBOP_CRM_BOTH);
			dataTlbFlush <= doWrite && primary_coproc_register == `CP_REG_TLBOP &&
				(secondary_coproc_register == `TLBOP_CRM_DATA || secondary_coproc_register == `TLBOP_CRM_BOTH);
			if (doWrite && primary_coproc_register == `CP_REG_CACHEOP)
			begin
				cacheOpCode <= op2;
				cacheOpSelect <= secondary_coproc_register;
				cacheOpData <= cpWriteData;
			end
			if (doWrite && primary_coproc_register == `CP_REG_TLBOP)
				tlbOpData <= cpWriteData;
		end
	end

	// Instruction fetches are always word sized and never writes.
	mmu_fault_check instrCheck
	(
		.mmuOn(mmuEnable),
		.alignOn(alignCheckEnable),
		.sysProt(controlWord[`CTRL_SYS_PROT]),
		.romProt(controlWord[`CTRL_ROM_PROT]),
		.privileged(cpPrivileged),
		.domainAccess(domainAccess),
		.addr(iAccAddr),
		.size(2'h2),
		.write(1'b0),
		.descValid(iDescValid),
		.pageSize(iPageSize),
		.domain(iDomain),
		.apAll(iApAll),
		.lineAbort(iLineAbort),
		.memAbort(iMemAbort),
		.walkAbort(iWalkAbort),
		.walkLevel2(iWalkLevel2),
		.fault(iFault),
		.status(iStatus)
	);

	mmu_fault_check dataCheck
	(
		.mmuOn(mmuEnable),
		.alignOn(alignCheckEnable),
		.sysProt(controlWord[`CTRL_SYS_PROT]),
		.romProt(controlWord[`CTRL_ROM_PROT]),
		.privileged(cpPrivileged),
		.domainAccess(domainAccess),
		.addr(dAccAddr),
		.size(dAccSize),
		.write(dAccWrite),
		.descValid(dDescValid),
		.pageSize(dPageSize),
		.domain(dDomain),
		.apAll(dApAll),
		.lineAbort(dLineAbort),
		.memAbort(dMemAbort),
		.walkAbort(dWalkAbort),
		.walkLevel2(dWalkLevel2),
		.fault(dFault),
		.status(dStatus)
	);

	assign dataFault = dAccValid & dFault;

	// Aborts, and recording of data faults; a fault wins over a same-cycle write.
	always @(posedge sys_clk or negedge rstSync)
	begin
		if (!rstSync)
		begin
			instrAbort <= 1'b0;
			dataAbort <= 1'b0;
			faultStatus <= `ZERO_RESET;
			faultAddress <= `ZERO_RESET;
		end
		else
		begin
			instrAbort <= iAccValid & iFault;
			dataAbort <= dataFault;
			if (dataFault)
			begin
				faultStatus <= {24'h000000, dDomain, dStatus};
				faultAddress <= dAccAddr;
			end
			else if (doWrite && primary_coproc_register == `CP_REG_FSR)
				faultStatus <= cpWriteData;
			else if (doWrite && primary_coproc_register == `CP_REG_FAR)
				faultAddress <= cpWriteData;
		end
	end
endmodule

// ### testbench/scc_checker.sv
// Port assertions for the control coprocessor and fault reporting.
`timescale 1ns/10ps
module scc_checker
(
	input wire sys_clk,
	input wire rstn,
	input wire [2:0] compactRegNum,
	input wire [3:0] physRegNum,
	input wire cpInstrValid,
	input wire [31:0] cpInstr,
	input wire cpCondPass,
	input wire cpPrivileged,
	input wire cpDone,
	input wire cpUndefined,
	input wire cpReadValid,
	input wire mmuEnable,
	input wire alignCheckEnable,
	input wire [31:0] controlWord,
	input wire instrAbort,
	input wire dAccValid,
	input wire [31:0] dAccAddr,
	input wire [1:0] dAccSize,
	input wire dataAbort,
	input wire [31:0] faultStatus,
	input wire [31:0] faultAddress
);
	wire ours;
	reg [3:0] upCnt;
	assign ours = cpInstrValid && cpCondPass && cpInstr[11:8] == 4'hF;
	// Checks wait until the design's own synchronised reset has let go.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			upCnt <= 4'h0;
		else
			upCnt <= {upCnt[2:0], 1'b1};
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!upCnt[3]);
	one_answer_a: assert property (!(cpDone && cpUndefined))
		else $error("done and undefined together");
	read_pair_a: assert property (cpReadValid |-> cpDone)
		else $error("read data without completion");
	unpriv_trap_a: assert property (ours && cpInstr[27:24] == 4'hE && !cpPrivileged
		|=> cpUndefined && !cpReadValid)
		else $error("user mode transfer not trapped");
	dataop_trap_a: assert property (ours && cpInstr[27:24] == 4'hE && !cpInstr[4]
		|=> cpUndefined)
		else $error("data operation not trapped");
	memop_trap_a: assert property (ours && cpInstr[27:25] == 3'h6 |=> cpUndefined)
		else $error("load or store not trapped");
	foreign_quiet_a: assert property (cpInstrValid && (!cpCondPass || cpInstr[11:8] != 4'hF)
		|=> !cpDone && !cpUndefined)
		else $error("answer to foreign instruction");
	compact_map_a: assert property (1'b1 |=> physRegNum == {1'b0, $past(compactRegNum)})
		else $error("compact register mapping wrong");
	ctrl_bits_a: assert property (mmuEnable == controlWord[0]
		&& alignCheckEnable == controlWord[1])
		else $error("enable bits differ from control");
	ifault_quiet_a: assert property (instrAbort && !dataAbort && !cpDone
		|-> $stable(faultStatus) && $stable(faultAddress))
		else $error("fetch fault touched fault registers");
	align_rec_a: assert property (dAccValid && alignCheckEnable && dAccAddr[0] && dAccSize != 2'h0
		|=> dataAbort && faultStatus[3:0] == 4'h1 && faultAddress == $past(dAccAddr))
		else $error("alignment fault not recorded");
endmodule

// ### testbench/core_model.sv
// Core pipeline model that issues coprocessor transfers.
`timescale 1ns/10ps
module core_model
(
	input wire sys_clk,
	output reg cpInstrValid,
	output reg [31:0] cpInstr,
	output reg cpCondPass,
	output reg cpPrivileged,
	output reg [31:0] cpWriteData,
	input wire cpDone,
	input wire cpUndefined,
	input wire cpReadValid
);
	reg [2:0] seen;
	initial
	begin
		cpInstrValid = 1'b0;
		cpInstr = 32'h0;
		cpCondPass = 1'b0;
		cpPrivileged = 1'b0;
		cpWriteData = 32'h0;
		seen = 3'h0;
	end
	// Idle instruction and write-data lines show the inverse of their last word so nothing stale looks valid.
	task issue(input [31:0] ins, input priv, input pass, input [31:0] wd, input [3:0] gap);
		integer k;
		begin
			for (k = 0; k < gap; k = k + 1)
				@(posedge sys_clk);
			@(posedge sys_clk);
			cpInstrValid <= 1'b1;
			cpInstr <= ins;
			cpCondPass <= pass;
			cpPrivileged <= priv;
			cpWriteData <= wd;
			@(posedge sys_clk);
			cpInstrValid <= 1'b0;
			cpInstr <= ~ins;
			cpWriteData <= ~wd;
			#1;
			seen = {cpDone, cpUndefined, cpReadValid};
		end
	endtask
endmodule

// ### testbench/tb_top.sv
// Testbench for the control coprocessor port and fault reporting.
`timescale 1ns/10ps
`include "sys_copro_regs.vh"
module tb_top;
	localparam [31:0] IDV = 32'h5EED0001; // Arbitrary identification value.
	localparam [31:0] CTV = 32'h5EED0002; // Arbitrary cache type value.
	localparam [23:0] RWL = {4'h2, 4'h3, 4'h5, 4'h6, 4'h9, 4'hD};
	localparam [39:0] BADL = {5'h00, 5'h17, 5'h18, 5'h04, 5'h1B, 5'h0C, 5'h1E, 5'h0F};
	reg sys_clk = 1'b0;
	reg rstn = 1'b0;
	reg [2:0] compactRegNum = 3'h0;
	reg iAccValid = 1'b0, iDescValid = 1'b0, dAccValid = 1'b0, dDescValid = 1'b0;
	reg dLineAbort = 1'b0, dMemAbort = 1'b0, dWalkAbort = 1'b0, wl2 = 1'b0;
	reg [31:0] iAccAddr = 32'h0, dAccAddr = 32'h0;
	reg [1:0] dAccSize = 2'h0, pgSize = 2'h0;
	reg [3:0] dDomain = 4'h2;
	wire cpInstrValid, cpCondPass, cpPrivileged, cpDone, cpUndefined, cpReadValid;
	wire [31:0] cpInstr, cpWriteData, cpReadData, faultStatus, faultAddress;
	wire [3:0] physRegNum, cpReadReg;
	wire mmuEnable, instrTlbFlush, dataTlbFlush, instrAbort, dataAbort;
	wire alignCheckEnable, cacheOpStrobe;
	wire [3:0] cacheOpSelect;
	wire [31:0] cacheOpData, tlbOpData, instrTlbLockdown, dataTlbLockdown;
	integer errorCnt = 0, testsRun = 0, cycles = 0, i;
	system_control_coprocessor #(.IDENT_CODE(IDV), .CACHE_TYPE(CTV))
		i_system_control_coprocessor
	(
		.sys_clk, .rstn, .compactRegNum, .physRegNum, .cpInstrValid, .cpInstr, .cpCondPass,
		.cpPrivileged, .cpWriteData, .cpDone, .cpUndefined, .cpReadValid, .cpReadReg,
		.cpReadData, .mmuEnable, .alignCheckEnable, .controlWord(), .tableBase(),
		.processIdRemap(), .cacheLockdown(), .instrTlbLockdown, .dataTlbLockdown,
		.cacheOpStrobe, .cacheOpCode(), .cacheOpSelect, .cacheOpData, .instrTlbFlush,
		.dataTlbFlush, .tlbOpData, .iAccValid, .iAccAddr, .iDescValid, .iPageSize(pgSize),
		.iDomain(dDomain), .iApAll(8'h0), .iLineAbort(dLineAbort), .iMemAbort(dMemAbort),
		.iWalkAbort(dWalkAbort), .iWalkLevel2(wl2), .instrAbort, .dAccValid, .dAccAddr,
		.dAccSize, .dAccWrite(1'b0), .dDescValid, .dPageSize(pgSize), .dDomain, .dApAll(8'h0),
		.dLineAbort, .dMemAbort, .dWalkAbort, .dWalkLevel2(wl2), .dataAbort, .faultStatus,
		.faultAddress
	);
	core_model core
	(
		.sys_clk, .cpInstrValid, .cpInstr, .cpCondPass, .cpPrivileged, .cpWriteData, .cpDone,
		.cpUndefined, .cpReadValid
	);
	initial
		forever #2 sys_clk = ~sys_clk;
	function [31:0] mk(input d, input [3:0] n, input [2:0] o2, input [3:0] m);
		mk = {8'hEE, 3'h0, d, n, 4'h3, 4'hF, o2, 1'b1, m};
	endfunction
	task chk(input string nm, input [31:0] ex, input [31:0] got);
		begin
			testsRun = testsRun + 1;
			if (got !== ex)
			begin
				errorCnt = errorCnt + 1;
				$display("BAD %s expected %h seen %h", nm, ex, got);
			end
		end
	endtask
	task xfer(input [31:0] ins, input priv, input pass, input [31:0] wd, input [2:0] ex);
		begin
			core.issue(ins, priv, pass, wd, {2'h0, testsRun[1:0]});
			chk("answer", {29'h0, ex}, {29'h0, core.seen});
		end
	endtask
	task rd(input [3:0] n, input [31:0] ex);
		begin
			xfer(mk(1'b1, n, 3'h0, 4'h0), 1'b1, 1'b1, 32'h0, 3'b101);
			chk("readData", ex, cpReadData);
		end
	endtask
	task wr(input [3:0] n, input [3:0] m, input [31:0] wd);
		xfer(mk(1'b0, n, 3'h0, m), 1'b1, 1'b1, wd, 3'b100);
	endtask
	task acc(input [31:0] a, input [1:0] sz, input [6:0] ctl, input ab, input [3:0] code);
		begin
			@(posedge sys_clk);
			dAccValid <= 1'b1;
			dAccAddr <= a;
			dAccSize <= sz;
			{pgSize, dDescValid, dWalkAbort, dLineAbort, dMemAbort, wl2} <= ctl;
			@(posedge sys_clk);
			dAccValid <= 1'b0;
			dAccAddr <= ~a;
			#1;
			chk("dataAbort", {31'h0, ab}, {31'h0, dataAbort});
			chk("faultCode", {28'h0, code}, {28'h0, faultStatus[3:0]});
		end
	endtask
	task close_out;
		begin
			if (errorCnt == 0 && testsRun > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			errorCnt = errorCnt + 1;
			close_out;
		end
	end
	initial
	begin
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		compactRegNum <= 3'h5;
		repeat (3) @(posedge sys_clk);
		#1;
		chk("physReg", 32'h5, {28'h0, physRegNum});
		rd(4'h1, `CTRL_RESET);
		chk("readReg", 32'h3, {28'h0, cpReadReg});
		rd(4'h0, IDV);
		xfer(mk(1'b1, 4'h0, 3'h1, 4'h0), 1'b1, 1'b1, 32'h0, 3'b101);
		chk("cacheType", CTV, cpReadData);
		xfer(mk(1'b0, 4'hA, 3'h1, 4'h0), 1'b1, 1'b1, 32'h00000011, 3'b100);
		wr(4'hA, 4'h0, 32'h00000022);
		chk("instrLock", 32'h00000011, instrTlbLockdown);
		chk("dataLock", 32'h00000022, dataTlbLockdown);
		xfer(mk(1'b1, 4'hA, 3'h1, 4'h0), 1'b1, 1'b1, 32'h0, 3'b101);
		chk("readData", 32'h00000011, cpReadData);
		rd(4'hA, 32'h00000022);
		wr(4'h7, 4'h5, 32'h0000C0DE);
		chk("cacheOp", 32'h15, {27'h0, cacheOpStrobe, cacheOpSelect});
		chk("cacheData", 32'h0000C0DE, cacheOpData);
		for (i = 0; i < 6; i = i + 1)
		begin
			wr(RWL[i*4 +: 4], 4'h0, 32'hA5000000 | RWL[i*4 +: 4]);
			rd(RWL[i*4 +: 4], 32'hA5000000 | RWL[i*4 +: 4]);
		end
		for (i = 0; i < 8; i = i + 1)
			xfer(mk(BADL[i*5+4], BADL[i*5 +: 4], 3'h0, 4'h0), 1'b1, 1'b1, 32'h1, 3'b010);
		xfer(mk(1'b1, 4'h1, 3'h0, 4'h0), 1'b0, 1'b1, 32'h0, 3'b010);
		xfer(mk(1'b1, 4'h1, 3'h0, 4'h0) & ~32'h10, 1'b1, 1'b1, 32'h0, 3'b010);
		xfer(32'hED910F00, 1'b1, 1'b1, 32'h0, 3'b010);
		xfer(mk(1'b1, 4'h1, 3'h0, 4'h0) ^ 32'h100, 1'b1, 1'b1, 32'h0, 3'b000);
		xfer(mk(1'b1, 4'h1, 3'h0, 4'h0), 1'b1, 1'b0, 32'h0, 3'b000);
		wr(4'h8, 4'h5, 32'h0);
		chk("tlbFlush", 32'h2, {30'h0, instrTlbFlush, dataTlbFlush});
		wr(4'h8, 4'h6, 32'h00000086);
		chk("tlbData", 32'h00000086, tlbOpData);
		chk("tlbFlush", 32'h1, {30'h0, instrTlbFlush, dataTlbFlush});
		wr(4'h1, 4'h0, 32'h2);
		chk("alignOn", 32'h1, {31'h0, alignCheckEnable});
		acc(32'h1001, 2'h2, 7'h00, 1'b1, 4'h1);
		chk("faultAddr", 32'h1001, faultAddress);
		acc(32'h2000, 2'h2, 7'h00, 1'b0, 4'h1);
		wr(4'h1, 4'h0, 32'h3);
		chk("mmuOn", 32'h1, {31'h0, mmuEnable});
		wr(4'h3, 4'h0, 32'h0);
		acc(32'h2000, 2'h2, 7'h00, 1'b1, 4'h5);
		acc(32'h2000, 2'h2, 7'h40, 1'b1, 4'h7);
		acc(32'h2000, 2'h2, 7'h10, 1'b1, 4'h9);
		acc(32'h2000, 2'h2, 7'h18, 1'b1, 4'hC);
		wr(4'h3, 4'h0, 32'h30);
		acc(32'h2000, 2'h2, 7'h14, 1'b1, 4'h4);
		acc(32'h2000, 2'h2, 7'h54, 1'b1, 4'h6);
		acc(32'h2000, 2'h2, 7'h19, 1'b1, 4'hE);
		acc(32'h2000, 2'h2, 7'h12, 1'b1, 4'h8);
		acc(32'h2000, 2'h2, 7'h10, 1'b0, 4'h8);
		acc(32'h2003, 2'h0, 7'h10, 1'b0, 4'h8);
		@(posedge sys_clk);
		iAccValid <= 1'b1;
		iAccAddr <= 32'h3000;
		@(posedge sys_clk);
		iAccValid <= 1'b0;
		#1;
		chk("instrAbort", 32'h1, {31'h0, instrAbort});
		chk("faultCode", 32'h8, {28'h0, faultStatus[3:0]});
		close_out;
	end
endmodule
bind system_control_coprocessor scc_checker i_scc_checker
(
	.sys_clk, .rstn, .compactRegNum, .physRegNum, .cpInstrValid, .cpInstr, .cpCondPass,
	.cpPrivileged, .cpDone, .cpUndefined, .cpReadValid, .mmuEnable, .alignCheckEnable,
	.controlWord, .instrAbort, .dAccValid, .dAccAddr, .dAccSize, .dataAbort, .faultStatus,
	.faultAddress
);
